// File: hdl/ssc_spi_core.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - fifo error flag with transmit empty means transmit underflow
// - fifo error flag with receive full means receive overflow
// - fifo initialize clears the fifo error flag
// - status bit 2 shows a byte receive interrupt fired
// - status bit 1 shows a byte transmit interrupt fired
// - status bit 0 shows a block transfer interrupt fired
// - writing one to clear bit 1 clears the byte transmit interrupt
// - writing one to clear bit 0 clears the block interrupt
// - two-bit mode picks one of three polynomials, code 11 reserved
// - checksum only advances while its enable bit 13 is one
// - checksum clear presets value to all ones, reads back zero
// - full duplex stream select picks receive or transmit bits
// - bit 10 reads one when checksum is not all zeros
// - bit 9 reads one when checksum is not all ones
// - checksum is sixteen bits, seven-bit mode uses bits 6 to 0
// - data read in byte mode returns low byte and pops fifo
// - data write in byte mode starts a transfer of set length
// - transmit dma fetches from the sixteen-bit base address
// - in byte mode, length field zero sends eight bits, else that many bits
// - byte mode bit picks programmed bytes or block dma
// - dma length comes from the eleven-bit count field
module ssc_spi_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ssc_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   output logic dma_req,
   output logic [15:0] dma_addr,
   input wire logic dma_ack,
   input wire logic [7:0] dma_rdata
);
   import ssc_pkg::*;

   // register address match
   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [15:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   // bits in a transfer, zero field means a full byte
   function automatic logic [3:0] nbits(input logic [2:0] f);
      nbits = (f == 3'b000) ? FULL_BYTE : {1'b0, f};
   endfunction

   // one serial bit through the selected polynomial
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic b,
                                            input logic [1:0] m);
      logic fb;
      logic [15:0] p;
      fb = b ^ ((m == MODE_SEVEN) ? c[6] : c[15]);
      unique case (m)
         MODE_CCITT: p = POLY_CCITT;
         MODE_SEVEN: p = POLY_SEVEN;
         MODE_STICK: p = POLY_STICK;
         MODE_RSV: p = POLY_RSV;
      endcase
      crc_step = {c[14:0], 1'b0} ^ (fb ? p : 16'h0000);
   endfunction

   logic pready_r, pslverr_r;
   logic [31:0] prdata_r;
   logic [2:0] sck_s_r;
   logic [1:0] cs_s_r, mosi_s_r;
   logic byte_r, fdx_r, rden_r;
   logic [2:0] txl_r, rxl_r;
   logic [1:0] mode_r;
   logic cen_r, crxs_r;
   logic [15:0] crc_r, txb_r;
   logic [10:0] txn_r, left_r;
   logic ferr_r, rxi_r, txi_r, blki_r;
   logic [7:0] fifo_r [0:7];
   logic [2:0] wp_r, rp_r;
   logic [3:0] cnt_r, rxc_r, txc_r;
   logic [7:0] rxsh_r, txsh_r;
   logic miso_r, oe_r, dreq_r, sent_r;
   logic [15:0] daddr_r;
   ssc_state_e state_r, state_nxt;

   // apb access phases
   wire acc = psel & penable;
   wire wr_go = acc & pready_r & pwrite;
   wire rd_go = acc & pready_r & ~pwrite;
   wire first = acc & ~pready_r;

   // address decode
   wire h_ctrl = hit(paddr, IDX_CTRL);
   wire h_stat = hit(paddr, IDX_STAT);
   wire h_iclr = hit(paddr, IDX_ICLR);
   wire h_cctl = hit(paddr, IDX_CCTL);
   wire h_cval = hit(paddr, IDX_CVAL);
   wire h_data = hit(paddr, IDX_DATA);
   wire h_txb = hit(paddr, IDX_TXB);
   wire h_txn = hit(paddr, IDX_TXN);
   wire h_any = h_ctrl | h_stat | h_iclr | h_cctl | h_cval | h_data |
                h_txb | h_txn;

   // write strobes, taken at the completing edge
   wire w_ctrl = wr_go & h_ctrl;
   wire w_cctl = wr_go & h_cctl;
   wire w_cval = wr_go & h_cval;
   wire w_iclr = wr_go & h_iclr;
   wire fifo_init = w_ctrl & pwdata[B_FINIT];
   wire crc_clr = w_cctl & pwdata[B_CCLR];

   // link edges, read from the second stage on
   wire srise = sck_s_r[1] & ~sck_s_r[2];
   wire sfall = ~sck_s_r[1] & sck_s_r[2];
   wire cs_act = ~cs_s_r[1];
   wire tick = srise & cs_act;
   wire mosi_b = mosi_s_r[1];

   // sequencer decode
   wire st_idle = (state_r == ST_IDLE);
   wire st_fetch = (state_r == ST_FETCH);
   wire st_send = (state_r == ST_SEND);
   wire data_wr = wr_go & h_data & byte_r & st_idle;
   wire dma_start = wr_go & h_txn & ~byte_r & st_idle &
                    (pwdata[10:0] != 11'h000);
   wire dma_load = st_fetch & dma_ack;
   wire tx_load = data_wr | dma_load;
   wire tx_done = st_send & tick & (txc_r == 4'h1);
   wire tx_shift = st_send & sfall & cs_act & sent_r;
   wire [3:0] exp_bits = nbits(txl_r);
   wire [3:0] ld_bits = st_fetch ? FULL_BYTE : exp_bits;
   wire [7:0] ld_val = st_fetch ? dma_rdata : pwdata[7:0];
   wire [7:0] ld_al = 8'(ld_val << (FULL_BYTE - ld_bits));

   // receive fifo decode
   wire f_empty = (cnt_r == 4'h0);
   wire f_full = (cnt_r == FIFO_FULL);
   wire [3:0] rxc_inc = 4'(rxc_r + 4'h1);
   wire push = tick & (rxc_inc == nbits(rxl_r));
   wire push_ok = push & ~f_full & ~fifo_init;
   wire pop = rd_go & h_data & byte_r & ~f_empty;
   wire [7:0] rx_byte = {rxsh_r[6:0], mosi_b};

   // event flags, a set in the clearing cycle wins
   wire under = tick & st_idle & ~rden_r;
   wire over = push & f_full;
   wire ferr_set = under | over;
   wire txi_set = tx_done & (left_r == 11'h000);
   wire blk_set = tx_done & (left_r == 11'h001);
   wire rxi_clr = pop & (cnt_r == 4'h1) & ~push_ok;
   wire txi_clr = w_iclr & pwdata[B_CTX];
   wire blk_clr = w_iclr & pwdata[B_CBLK];

   // checksum input stream
   wire use_rx = fdx_r ? crxs_r : ~st_send;
   wire crc_bit = use_rx ? mosi_b : txsh_r[7];
   wire crc_one = |crc_r;
   wire crc_zero = ~&crc_r;

   // read data selection
   wire [15:0] ctrl_rd = {2'b00, byte_r, fdx_r, 1'b0, rden_r, st_idle,
                          ~f_empty, st_idle, f_full, txl_r, rxl_r};
   wire [15:0] stat_rd = {8'h00, ferr_r, 4'h0, rxi_r, txi_r, blki_r};
   wire [15:0] cctl_rd = {mode_r, cen_r, 1'b0, crxs_r, crc_one, crc_zero,
                          9'h000};
   wire [15:0] rd_val = h_ctrl ? ctrl_rd :
                        h_stat ? stat_rd :
                        h_cctl ? cctl_rd :
                        h_cval ? crc_r :
                        h_data ? {8'h00, fifo_r[rp_r]} :
                        h_txb ? txb_r :
                        h_txn ? {5'h00, txn_r} : 16'h0000;

   // apb slave answers one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= first;
         pslverr_r <= first & ~h_any;
         if (first & ~pwrite) prdata_r <= {16'h0000, rd_val};
      end
   end

   // two-stage synchronisers, third sck stage for edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_s_r <= 3'b000;
         cs_s_r <= 2'b11;
         mosi_s_r <= 2'b00;
      end else begin
         sck_s_r <= {sck_s_r[1:0], spi_sck};
         cs_s_r <= {cs_s_r[0], spi_cs_n};
         mosi_s_r <= {mosi_s_r[0], spi_mosi};
      end
   end

   // port control and dma registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_r <= 1'b0;
         fdx_r <= 1'b0;
         rden_r <= 1'b0;
         txl_r <= 3'h0;
         rxl_r <= 3'h0;
         txb_r <= 16'h0000;
         txn_r <= 11'h000;
      end else begin
         if (w_ctrl) begin
            byte_r <= pwdata[B_BYTE];
            fdx_r <= pwdata[B_FDX];
            rden_r <= pwdata[B_RDEN];
            txl_r <= pwdata[TXL_LSB +: 3];
            rxl_r <= pwdata[RXL_LSB +: 3];
         end
         if (wr_go & h_txb) txb_r <= pwdata[15:0];
         if (wr_go & h_txn) txn_r <= pwdata[10:0];
      end
   end

   // checksum control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= MODE_CCITT;
         cen_r <= 1'b0;
         crxs_r <= 1'b0;
      end else if (w_cctl) begin
         mode_r <= pwdata[CM_LSB +: 2];
         cen_r <= pwdata[B_CEN];
         crxs_r <= pwdata[B_CRXS];
      end
   end

   // checksum register: clear, load, then per-bit step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) crc_r <= CRC_RST;
      else if (crc_clr) crc_r <= CRC_RST;
      else if (w_cval) crc_r <= pwdata[15:0];
      else if (cen_r & tick) begin
         crc_r <= crc_step(crc_r, crc_bit, mode_r);
      end
   end

   // transmit sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (data_wr) state_nxt = ST_SEND;
            else if (dma_start) state_nxt = ST_FETCH;
         end
         ST_FETCH: begin
            if (dma_ack) state_nxt = ST_SEND;
         end
         ST_SEND: begin
            if (tx_done) begin
               state_nxt = (left_r > 11'h001) ? ST_FETCH : ST_IDLE;
            end
         end
      endcase
   end

   // sequencer state and dma address walk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         left_r <= 11'h000;
         daddr_r <= 16'h0000;
         dreq_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         dreq_r <= (state_nxt == ST_FETCH);
         if (dma_start) begin
            left_r <= pwdata[10:0];
            daddr_r <= txb_r;
         end else if (tx_done & (left_r != 11'h000)) begin
            left_r <= left_r - 11'h001;
            daddr_r <= daddr_r + 16'h0001;
         end
      end
   end

   // transmit shifter, msb first, one shift per taken bit, so a byte
   // loaded before the last fall of the previous byte keeps its msb
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txsh_r <= 8'h00;
         txc_r <= 4'h0;
         miso_r <= 1'b0;
         oe_r <= 1'b0;
         sent_r <= 1'b0;
      end else begin
         oe_r <= cs_act;
         if (tx_load) begin
            txsh_r <= ld_al;
            txc_r <= ld_bits;
            miso_r <= ld_al[7];
            sent_r <= 1'b0;
         end else if (st_send & tick) begin
            txc_r <= txc_r - 4'h1;
            sent_r <= 1'b1;
         end else if (tx_shift) begin
            txsh_r <= {txsh_r[6:0], 1'b0};
            miso_r <= txsh_r[6];
            sent_r <= 1'b0;
         end
      end
   end

   // receive shifter counts bits of the receive length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxsh_r <= 8'h00;
         rxc_r <= 4'h0;
      end else if (!cs_act) begin
         rxc_r <= 4'h0;
      end else if (tick) begin
         rxsh_r <= rx_byte;
         rxc_r <= push ? 4'h0 : rxc_inc;
      end
   end

   // receive fifo storage
   always_ff @(posedge pclk) begin
      if (push_ok) fifo_r[wp_r] <= rx_byte;
   end

   // receive fifo pointers, read pops one entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r <= 3'h0;
         rp_r <= 3'h0;
         cnt_r <= 4'h0;
      end else if (fifo_init) begin
         wp_r <= 3'h0;
         rp_r <= 3'h0;
         cnt_r <= 4'h0;
      end else begin
         if (push_ok) wp_r <= wp_r + 3'h1;
         if (pop) rp_r <= rp_r + 3'h1;
         cnt_r <= cnt_r + {3'h0, push_ok} - {3'h0, pop};
      end
   end

   // sticky event flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ferr_r <= 1'b0;
         rxi_r <= 1'b0;
         txi_r <= 1'b0;
         blki_r <= 1'b0;
      end else begin
         ferr_r <= ferr_set | (ferr_r & ~fifo_init);
         rxi_r <= push_ok | (rxi_r & ~rxi_clr);
         txi_r <= txi_set | (txi_r & ~txi_clr);
         blki_r <= blk_set | (blki_r & ~blk_clr);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign spi_miso = miso_r;
   assign spi_miso_oe = oe_r;
   assign dma_req = dreq_r;
   assign dma_addr = daddr_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_dma_go;
      st_fetch && dreq_r && daddr_r == $past(txb_r);
   endsequence

   a_under_flag: assert property (under |=> ferr_r)
      else $error("underflow did not raise fifo error");
   a_over_flag: assert property (over |=> ferr_r && f_full)
      else $error("overflow did not raise fifo error");
   a_init_clear: assert property (fifo_init && !ferr_set |=> !ferr_r)
      else $error("fifo init left error flag set");
   a_rx_flag: assert property (push_ok |=> rxi_r && !f_empty)
      else $error("receive flag not set on push");
   a_txi_clear: assert property (w_iclr && pwdata[B_CTX] && !txi_set
      |=> !txi_r)
      else $error("transmit flag not cleared");
   a_blk_flag: assert property (blk_set |=> blki_r && st_idle)
      else $error("block flag not set at dma end");
   a_crc_hold: assert property (!cen_r && !w_cval && !crc_clr
      |=> $stable(crc_r))
      else $error("checksum moved while disabled");
   a_crc_preset: assert property (crc_clr |=> crc_r == CRC_RST
      && !cctl_rd[B_CCLR] && !crc_zero)
      else $error("checksum clear did not preset ones");
   a_byte_len: assert property (data_wr |=> st_send
      && txc_r == $past(exp_bits))
      else $error("byte transfer length wrong");
   a_dma_base: assert property (dma_start |=> s_dma_go)
      else $error("dma did not start at base address");
endmodule // ssc_spi_core
`default_nettype wire

// File: hdl/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
   // apb address width, enough for the highest index times four
   localparam int AW = 18;

   // register indices, byte address is the index times four
   localparam logic [15:0] IDX_CTRL = 16'hC0CA;
   localparam logic [15:0] IDX_STAT = 16'hC0CE;
   localparam logic [15:0] IDX_ICLR = 16'hC0D0;
   localparam logic [15:0] IDX_CCTL = 16'hC0D2;
   localparam logic [15:0] IDX_CVAL = 16'hC0D4;
   localparam logic [15:0] IDX_DATA = 16'hC0D6;
   localparam logic [15:0] IDX_TXB = 16'hC0D8;
   localparam logic [15:0] IDX_TXN = 16'hC0DA;

   // port control fields
   localparam int B_FINIT = 14;
   localparam int B_BYTE = 13;
   localparam int B_FDX = 12;
   localparam int B_RDEN = 10;
   localparam int TXL_LSB = 3;
   localparam int RXL_LSB = 0;

   // status and interrupt clear fields
   localparam int B_FERR = 7;
   localparam int B_CTX = 1;
   localparam int B_CBLK = 0;

   // checksum control fields
   localparam int CM_LSB = 14;
   localparam int B_CEN = 13;
   localparam int B_CCLR = 12;
   localparam int B_CRXS = 11;

   // checksum polynomials and preset
   localparam logic [1:0] MODE_CCITT = 2'h0;
   localparam logic [1:0] MODE_SEVEN = 2'h1;
   localparam logic [1:0] MODE_STICK = 2'h2;
   localparam logic [1:0] MODE_RSV = 2'h3;
   localparam logic [15:0] POLY_CCITT = 16'h1021;
   localparam logic [15:0] POLY_SEVEN = 16'h0009;
   localparam logic [15:0] POLY_STICK = 16'h8005;
   localparam logic [15:0] POLY_RSV = 16'h0001;
   localparam logic [15:0] CRC_RST = 16'hFFFF;

   // receive fifo holds eight bytes
   localparam logic [3:0] FIFO_FULL = 4'h8;
   localparam logic [3:0] FULL_BYTE = 4'h8;

   // transmit sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_SEND = 3'b100
   } ssc_state_e;
endpackage
`default_nettype wire

// File: bench/ssc_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
// external spi master, mode 0, clock stands still between frames
module ssc_spi_master (
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe
);
   // idle link: clock low, deselected
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // one frame of n bits, msb first, miso taken at end of high phase
   task automatic xfer(input logic [31:0] tx, input int n, input int half,
                       output logic [31:0] rx);
      rx = '0;
      #3 spi_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         spi_mosi = tx[i];
         #half spi_sck = 1'b1;
         #half rx = {rx[30:0], spi_miso_oe ? spi_miso : 1'bx};
         spi_sck = 1'b0;
      end
      #half spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // inverted line, no stale level
   endtask
endmodule // ssc_spi_master
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ssc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, v, err, got, d, mk;
   logic pready, pslverr, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic dma_req, dma_ack = 0;
   logic [15:0] dma_addr, exp_addr, b;
   logic [7:0] dma_rdata = 8'h00;
   logic [7:0] q [9];
   logic [31:0] seed = 32'h1792;
   int n_mismatch = 0, n_tests = 0, dwait = 0, ndma = 0, n;

   always #4 pclk = ~pclk;

   ssc_spi_core i_ssc_spi_core (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .spi_sck, .spi_cs_n,
      .spi_mosi, .spi_miso, .spi_miso_oe, .dma_req, .dma_addr, .dma_ack,
      .dma_rdata);
   ssc_spi_master i_ssc_spi_master (.spi_sck, .spi_cs_n, .spi_mosi,
      .spi_miso, .spi_miso_oe);

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] mem(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   // bitwise checksum, msb first, seven-bit mode feeds back from bit 6
   function automatic logic [15:0] crc(input logic [15:0] c,
                                       input logic [7:0] x, input int m);
      logic [15:0] p [4];
      logic fb;
      p = '{16'h1021, 16'h0009, 16'h8005, 16'h0001};
      for (int i = 7; i >= 0; i--) begin
         fb = (m == 1 ? c[6] : c[15]) ^ x[i];
         c = {c[14:0], 1'b0} ^ ({16{fb}} & p[m]);
      end
      return c;
   endfunction

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // apb transfer: setup, access until pready, then release
   task automatic apb(input logic wr, input logic [15:0] idx,
                      input logic [15:0] wd);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge pclk) penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
         n_mismatch++;
         report_and_stop();
      end
      v = prdata;
      err = {31'h0, pslverr};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wreg(input logic [15:0] i, input logic [15:0] x);
      apb(1'b1, i, x);
   endtask
   task automatic rreg(input logic [15:0] i);
      apb(1'b0, i, 16'h0000);
   endtask
   task automatic sx(input logic [31:0] x, input int bits, input int half);
      i_ssc_spi_master.xfer(x, bits, half, got);
      repeat (8) @(posedge pclk);
   endtask
   task tend(input string s);
      $display("test %s done", s);
   endtask

   // memory behind the transmit dma, answers after a random wait
   always @(posedge pclk) begin
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata;
      if (dma_req === 1'b1 && dma_ack !== 1'b1) begin
         if (dwait == 0) begin
            chk({16'h0, dma_addr}, {16'h0, exp_addr});
            dma_ack <= 1'b1;
            dma_rdata <= mem(dma_addr);
            exp_addr <= exp_addr + 16'h1;
            ndma <= ndma + 1;
            dwait <= int'(rnd() & 32'h3);
         end else
            dwait <= dwait - 1;
      end
   end

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, unmapped and read-only places
      rreg(IDX_CCTL);
      chk(v, 32'h400);
      rreg(IDX_CVAL);
      chk(v, 32'hFFFF);
      rreg(IDX_TXB);
      chk(v, 32'h0);
      wreg(IDX_STAT, 16'h0087);
      rreg(IDX_STAT);
      chk(v, 32'h0);
      rreg(16'hC0E0);
      chk(err, 32'h1);
      tend("reset");
      // all-zero and all-ones flags
      for (int k = 0; k < 3; k++) begin
         b = k == 0 ? 16'h0 : k == 1 ? 16'hFFFF : 16'(rnd());
         wreg(IDX_CVAL, b);
         rreg(IDX_CCTL);
         mk = {21'h0, b != 0, b != 16'hFFFF, 9'h0};
         chk(v & 32'h600, mk);
      end
      tend("flags");
      // every polynomial, then disabled checksum holds
      wreg(IDX_CTRL, 16'h2400);
      for (int m = 0; m < 4; m++) begin
         wreg(IDX_CCTL, 16'(m << 14) | 16'h3000);
         rreg(IDX_CCTL);
         chk(v & 32'hF800, 32'(m << 14) | 32'h2000);
         rreg(IDX_CVAL);
         chk(v, 32'hFFFF);
         d = rnd();
         sx(d, 8, 32);
         mk = m == 1 ? 32'h7F : 32'hFFFF;
         rreg(IDX_CVAL);
         b = crc(16'hFFFF, d[7:0], m);
         chk(v & mk, {16'h0, b} & mk);
         b = v[15:0];
         wreg(IDX_CCTL, 16'(m << 14));
         sx(rnd(), 8, 32);
         rreg(IDX_CVAL);
         chk(v, {16'h0, b});
      end
      // full duplex stream select
      wreg(IDX_CTRL, 16'h3400);
      for (int s = 0; s < 2; s++) begin
         wreg(IDX_CCTL, 16'h3000 | 16'(s << 11));
         d = rnd();
         mk = rnd();
         wreg(IDX_DATA, {8'h00, d[7:0]});
         sx(mk, 8, 32);
         chk(got, d & 32'hFF);
         rreg(IDX_CVAL);
         b = crc(16'hFFFF, s ? mk[7:0] : d[7:0], 0);
         chk(v, {16'h0, b});
      end
      tend("checksum");
      // every transmit length, flag set and cleared
      wreg(IDX_CTRL, 16'h6000);
      for (int l = 0; l < 8; l++) begin
         wreg(IDX_CTRL, 16'h2000 | 16'(l << 3));
         wreg(IDX_ICLR, 16'h2);
         d = rnd();
         n = l == 0 ? 8 : l;
         wreg(IDX_DATA, d[15:0]);
         sx(d, n, 32);
         chk(got, d & ((32'h1 << n) - 1));
         rreg(IDX_STAT);
         chk(v & 32'h2, 32'h2);
         wreg(IDX_ICLR, 16'h0);
         rreg(IDX_STAT);
         chk(v & 32'h2, 32'h2);
         wreg(IDX_ICLR, 16'h2);
         rreg(IDX_STAT);
         chk(v & 32'h2, 32'h0);
      end
      tend("transmit");
      // clocks with nothing to send
      wreg(IDX_CTRL, 16'h6000);
      sx(rnd(), 8, 32);
      rreg(IDX_STAT);
      chk(v & 32'h80, 32'h80);
      rreg(IDX_CTRL);
      chk(v & 32'h80, 32'h80);
      wreg(IDX_CTRL, 16'h6000);
      rreg(IDX_STAT);
      chk(v & 32'h80, 32'h0);
      tend("underflow");
      // nine bytes into the eight-byte fifo, then drain
      wreg(IDX_CTRL, 16'h6400);
      for (int k = 0; k < 9; k++) begin
         q[k] = 8'(rnd());
         sx({24'h0, q[k]}, 8, 32);
      end
      rreg(IDX_STAT);
      chk(v & 32'h84, 32'h84);
      rreg(IDX_CTRL);
      chk(v & 32'h40, 32'h40);
      for (int k = 0; k < 8; k++) begin
         rreg(IDX_DATA);
         chk(v & 32'hFF, {24'h0, q[k]});
      end
      rreg(IDX_STAT);
      chk(v & 32'h4, 32'h0);
      tend("receive");
      // block transfer of three bytes from the dma base
      wreg(IDX_CTRL, 16'h4000);
      wreg(IDX_ICLR, 16'h1);
      b = 16'(rnd());
      exp_addr = b;
      wreg(IDX_TXB, b);
      rreg(IDX_TXB);
      chk(v, {16'h0, b});
      wreg(IDX_TXN, 16'hF803);
      rreg(IDX_TXN);
      chk(v, 32'h3);
      sx(32'h0, 24, 32);
      d = {8'h0, mem(b), mem(b + 16'h1), mem(b + 16'h2)};
      chk(got, d);
      chk(32'(ndma), 32'h3);
      rreg(IDX_STAT);
      chk(v & 32'h1, 32'h1);
      wreg(IDX_ICLR, 16'h0);
      rreg(IDX_STAT);
      chk(v & 32'h1, 32'h1);
      wreg(IDX_ICLR, 16'h1);
      rreg(IDX_STAT);
      chk(v & 32'h1, 32'h0);
      tend("dma");
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
